// *** src/xlc_entry_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
module xlc_entry_mem
(
  // Clock
  input  wire logic                                     mclk,
  // Read port, one set of all ways
  input  wire logic [xlc_pkg::SET_W-1:0]                rdSet,
  output logic [xlc_pkg::WAYS*xlc_pkg::ENTRY_W-1:0]     rdData,
  // Write port, one entry
  input  wire logic                                     wrEn,
  input  wire logic [xlc_pkg::SET_W-1:0]                wrSet,
  input  wire logic [xlc_pkg::WAY_W-1:0]                wrWay,
  input  wire logic [xlc_pkg::ENTRY_W-1:0]              wrData
);
  import xlc_pkg::*;

  // ----------------------------------------------------------------
  // One array per way; no reset, contents survive reset
  // ----------------------------------------------------------------
  genvar w;
  generate
    for (w = 0; w < WAYS; w++)
    begin : g_way
      logic [ENTRY_W-1:0] mem [SETS];  // Entries of this way
      logic [ENTRY_W-1:0] rdWay;       // Registered read data

      // Write selected way, read indexed set
      always_ff @(posedge mclk)
      begin
        if (wrEn && wrWay == WAY_W'(w))
        begin
          mem[wrSet] <= wrData;
        end
        rdWay <= mem[rdSet];
      end

      assign rdData[w*ENTRY_W +: ENTRY_W] = rdWay;
    end
  endgenerate
endmodule
`default_nettype wire

// *** src/xlc_pkg.sv ***
package xlc_pkg;
  // ----------------------------------------------------------------
  // Organisation
  // ----------------------------------------------------------------
  localparam int SETS    = 16;   // Sets of entries
  localparam int WAYS    = 4;    // Ways per set
  localparam int SET_W   = 4;    // Set index width
  localparam int WAY_W   = 2;    // Way number width
  localparam int IDX_W   = 6;    // Flat entry number width
  localparam int TAG_W   = 16;   // Logical tag width
  localparam int PA_W    = 20;   // Stored physical page width
  // ----------------------------------------------------------------
  // Stored entry layout (valid and global live in flops)
  // ----------------------------------------------------------------
  localparam int PA_LSB   = 0;   // Physical page
  localparam int RES_BIT  = 20;  // Resident
  localparam int WP_BIT   = 21;  // Write protected
  localparam int MOD_BIT  = 22;  // Modified
  localparam int CM_LSB   = 23;  // Cache policy field, 2 bits
  localparam int SUP_BIT  = 25;  // Supervisor only
  localparam int UA_LSB   = 26;  // User attributes lo, hi
  localparam int TAG_LSB  = 28;  // Logical tag
  localparam int PRIV_BIT = 44;  // Privilege of creating access
  localparam int ENTRY_W  = 45;  // Entry width
  // ----------------------------------------------------------------
  // Cache policy codes
  // ----------------------------------------------------------------
  localparam logic [1:0] CM_WTHRU  = 2'h0;  // Cachable writethrough
  localparam logic [1:0] CM_COPYB  = 2'h1;  // Cachable copyback
  localparam logic [1:0] CM_SERIAL = 2'h2;  // Inhibited serialized
  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL  = 12'h000;  // Control
  localparam logic [11:0] OFS_STAT  = 12'h004;  // Status
  localparam logic [11:0] OFS_FLUSH = 12'h008;  // Flush all command
  localparam logic [1:0]  CTRL_RST  = 2'h0;     // Control reset value
  localparam int CTRL_PG8K_BIT = 0;  // Page size 8K when set
  localparam int CTRL_EN_BIT   = 1;  // Translation enable
  localparam int FLUSH_NG_BIT  = 0;  // Flush nonglobal only
  localparam int STAT_MISS_BIT = 4;  // Last lookup missed
endpackage

// *** src/xlc_translation_cache.sv ***
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module xlc_translation_cache
(
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rstn,
  // APB register port
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Lookup request from the core
  input  wire logic                      lookupValid,
  input  wire logic [31:0]               lookupAddr,
  input  wire logic                      privilegeFlag,
  input  wire logic                      lookupWrite,
  input  wire logic                      lookupRmw,
  input  wire logic                      lookupAligned,
  // Lookup result to cache controller
  output logic                           resultValid,
  output logic [31:0]                    resultPhysAddr,
  output logic                           resultHit,
  output logic                           searchRequest,
  output logic                           modifySuspend,
  output logic                           busError,
  output logic                           cacheInhibitOutput,
  output logic                           copybackMode,
  output logic                           serializeHold,
  output logic                           userAttrOutLo,
  output logic                           userAttrOutHi,
  // Entry fill from the table walker
  input  wire logic                      fillValid,
  input  wire logic                      fillUpdate,
  input  wire logic [31:0]               fillAddr,
  input  wire logic                      fillPrivilege,
  input  wire logic                      fillGlobal,
  input  wire logic [xlc_pkg::PA_W-1:0]  fillPhysPage,
  input  wire logic                      userAttrBitLo,
  input  wire logic                      userAttrBitHi,
  input  wire logic                      fillSupOnly,
  input  wire logic [1:0]                cachePolicyField,
  input  wire logic                      fillModified,
  input  wire logic                      fillWriteProt,
  input  wire logic                      fillResident,
  // Flush requests
  input  wire logic                      selectiveFlushOp,
  input  wire logic                      flushEveryEntryOp,
  input  wire logic                      flushNonGlobal,
  input  wire logic [31:0]               flushAddr,
  input  wire logic                      flushPrivilege
);
  import xlc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0]               ctrl;        // Page size and enable
  logic                     pg8k;        // 8K page size selected
  logic                     xlEnable;    // Translation enabled
  logic [WAY_W-1:0]         replCount;   // Pseudo-random counter
  logic [SETS*WAYS-1:0]     entValid;    // Valid flags
  logic [SETS*WAYS-1:0]     entGlobal;   // Global flags
  logic                     swFlushAll;  // Flush all from software
  logic                     swFlushNg;   // Its nonglobal option
  logic                     anyFlushAll; // Flush all from any source
  logic                     anyFlushNg;  // Its nonglobal option
  logic                     apbWrite;    // Write takes effect
  logic [SET_W-1:0]         lkSet;       // Set of incoming request
  logic [31:0]              lkAddr;      // Address of incoming request
  logic [SET_W-1:0]         fillSet;     // Set of walker fill
  logic [WAYS*ENTRY_W-1:0]  setData;     // All ways of read set
  logic                     s1Lookup;    // Stage 1 holds a lookup
  logic                     s1Flush;     // Stage 1 holds a flush
  logic                     s1FlushNg;   // Flush spares globals
  logic [31:0]              s1Addr;      // Stage 1 logical address
  logic                     s1Super;     // Stage 1 privilege
  logic                     s1Write;     // Stage 1 write
  logic                     s1Rmw;       // Stage 1 read-modify-write
  logic                     s1Aligned;   // Stage 1 aligned access
  logic [SET_W-1:0]         s1Set;       // Stage 1 set
  logic [WAYS-1:0]          wayMatch;    // Per-way tag hit
  logic                     hitAny;      // Some way hit
  logic                     hitOn;       // Hit while translating
  logic [WAY_W-1:0]         hitWay;      // Hitting way
  logic [ENTRY_W-1:0]       hitEnt;      // Hitting entry
  logic                     accWrite;    // Access counts as a write
  logic                     next_busErr; // Fault on this hit
  logic                     next_modSus; // Modify suspension
  logic [31:0]              next_phys;   // Translated address
  logic [WAY_W-1:0]         missWay;     // Counter caught at miss
  logic [WAY_W-1:0]         modWay;      // Way to overwrite on update
  logic [SET_W-1:0]         modSet;      // Set to overwrite on update
  logic                     lastMiss;    // Last lookup missed
  logic [WAY_W-1:0]         freeWay;     // First invalid way of fill set
  logic                     freeFound;   // Fill set has invalid way
  logic                     wrEn;        // Entry write
  logic [SET_W-1:0]         wrSet;       // Entry write set
  logic [WAY_W-1:0]         wrWay;       // Entry write way
  logic [ENTRY_W-1:0]       wrData;      // Entry write data

  assign pg8k     = ctrl[CTRL_PG8K_BIT];
  assign xlEnable = ctrl[CTRL_EN_BIT];

  // ----------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------
  assign apbWrite = psel && penable && pready && pwrite;

  // Ready, error and read data prepared in the setup cycle
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (psel && !penable)
      begin
        case (paddr)
          OFS_CTRL:  prdata <= {30'h0, ctrl};
          OFS_STAT:  prdata <= {27'h0, lastMiss, 2'h0, replCount};
          OFS_FLUSH: prdata <= 32'h0;
          default:   pslverr <= 1'b1;  // Unmapped offset
        endcase
      end
    end
  end

  // Control register
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl <= CTRL_RST;
    end
    else if (apbWrite && paddr == OFS_CTRL)
    begin
      ctrl <= pwdata[1:0];
    end
  end

  // Software flush-all command pulse
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      swFlushAll <= 1'b0;
      swFlushNg  <= 1'b0;
    end
    else
    begin
      swFlushAll <= apbWrite && paddr == OFS_FLUSH;
      swFlushNg  <= pwdata[FLUSH_NG_BIT];
    end
  end

  assign anyFlushAll = flushEveryEntryOp || swFlushAll;
  assign anyFlushNg  = flushEveryEntryOp ? flushNonGlobal : swFlushNg;

  // ----------------------------------------------------------------
  // Request stage: set index and entry read
  // ----------------------------------------------------------------
  assign lkAddr  = selectiveFlushOp ? flushAddr : lookupAddr;
  assign lkSet   = pg8k ? lkAddr[16:13] : lkAddr[15:12];
  assign fillSet = pg8k ? fillAddr[16:13] : fillAddr[15:12];

  // Entry store, read in step with the data cache index
  xlc_entry_mem u_mem
  (
    .mclk   (mclk),
    .rdSet  (lkSet),
    .rdData (setData),
    .wrEn   (wrEn),
    .wrSet  (wrSet),
    .wrWay  (wrWay),
    .wrData (wrData)
  );

  // Stage 1 request capture; a flush wins over a lookup
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      {s1Lookup, s1Flush, s1FlushNg, s1Super, s1Write, s1Rmw, s1Aligned} <= '0;
      s1Addr    <= 32'h0;
      s1Set     <= '0;
    end
    else
    begin
      s1Lookup  <= lookupValid && !selectiveFlushOp;
      s1Flush   <= selectiveFlushOp;
      s1FlushNg <= flushNonGlobal;
      s1Addr    <= lkAddr;
      s1Super   <= selectiveFlushOp ? flushPrivilege : privilegeFlag;
      s1Write   <= lookupWrite;
      s1Rmw     <= lookupRmw;
      s1Aligned <= lookupAligned;
      s1Set     <= lkSet;
    end
  end

  // ----------------------------------------------------------------
  // Tag compare, one comparator per way
  // ----------------------------------------------------------------
  genvar w;
  generate
    for (w = 0; w < WAYS; w++)
    begin : g_cmp
      logic [ENTRY_W-1:0] ent;   // This way's entry
      logic [TAG_W-1:0]   tag;   // This way's tag
      assign ent = setData[w*ENTRY_W +: ENTRY_W];
      assign tag = ent[TAG_LSB +: TAG_W];
      // Valid, privilege and tag; tag LSB dropped for 8K
      assign wayMatch[w] = entValid[{s1Set, WAY_W'(w)}]
                         && ent[PRIV_BIT] == s1Super
                         && tag[TAG_W-1:1] == s1Addr[31:17]
                         && (pg8k || tag[0] == s1Addr[16]);
    end
  endgenerate

  // Select the hitting way
  always_comb
  begin
    hitAny = 1'b0;
    hitWay = '0;
    hitEnt = '0;
    for (int i = 0; i < WAYS; i++)
    begin
      if (wayMatch[i] && !hitAny)
      begin
        hitAny = 1'b1;
        hitWay = WAY_W'(i);
        hitEnt = setData[i*ENTRY_W +: ENTRY_W];
      end
    end
  end

  // ----------------------------------------------------------------
  // Hit checks and address formation
  // ----------------------------------------------------------------
  always_comb
  begin
    accWrite    = s1Write || s1Rmw;
    // Failed search, protection or privilege fault
    next_busErr = hitAny && (!hitEnt[RES_BIT]
                  || (hitEnt[WP_BIT] && accWrite)
                  || (hitEnt[SUP_BIT] && !s1Super));
    // First write to an unmodified page goes back to the walker
    next_modSus = hitAny && !next_busErr && accWrite
                  && !hitEnt[MOD_BIT];
    // Physical page joined with offset
    if (pg8k)
    begin
      next_phys = {hitEnt[PA_LSB+1 +: PA_W-1], s1Addr[12:0]};
    end
    else
    begin
      next_phys = {hitEnt[PA_LSB +: PA_W], s1Addr[11:0]};
    end
  end

  // ----------------------------------------------------------------
  // Result stage
  // ----------------------------------------------------------------
  // Attributes only while translating; pass-through shows zeros
  assign hitOn = s1Lookup && xlEnable && hitAny;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      {resultValid, resultHit, searchRequest, modifySuspend, busError} <= '0;
      {cacheInhibitOutput, copybackMode, serializeHold}               <= '0;
      {userAttrOutLo, userAttrOutHi}                                  <= '0;
      resultPhysAddr     <= 32'h0;
    end
    else
    begin
      resultValid        <= s1Lookup;
      resultPhysAddr     <= xlEnable ? next_phys : s1Addr;
      resultHit          <= s1Lookup && (hitAny || !xlEnable);
      searchRequest      <= s1Lookup && xlEnable
                            && (!hitAny || next_modSus);
      modifySuspend      <= hitOn && next_modSus;
      busError           <= hitOn && next_busErr;
      // Policy 1x bypasses the cache
      cacheInhibitOutput <= hitOn && hitEnt[CM_LSB+1];
      // Policy 01 copyback, 00 writethrough
      copybackMode       <= hitOn
                            && hitEnt[CM_LSB +: 2] == CM_COPYB;
      // Serialized aligned access is not interrupted
      serializeHold      <= hitOn && s1Aligned
                            && hitEnt[CM_LSB +: 2] == CM_SERIAL;
      // User attributes echoed for the bus transfer
      userAttrOutLo      <= hitOn && !next_busErr && hitEnt[UA_LSB];
      userAttrOutHi      <= hitOn && !next_busErr && hitEnt[UA_LSB+1];
    end
  end

  // ----------------------------------------------------------------
  // Replacement counter and miss bookkeeping
  // ----------------------------------------------------------------
  // Counter steps on every lookup while translating and wraps three to zero
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      replCount <= '0;
    end
    else if (lookupValid && !selectiveFlushOp && xlEnable)
    begin
      replCount <= replCount + WAY_W'(1);
    end
  end

  // Victim on miss, overwrite target on modify suspension
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      missWay  <= '0;
      modWay   <= '0;
      modSet   <= '0;
      lastMiss <= 1'b0;
    end
    else if (s1Lookup && xlEnable)
    begin
      lastMiss <= !hitAny;
      if (!hitAny)
      begin
        missWay <= replCount;
      end
      if (next_modSus)
      begin
        modWay <= hitWay;
        modSet <= s1Set;
      end
    end
  end

  // ----------------------------------------------------------------
  // Fill path
  // ----------------------------------------------------------------
  // First invalid way of the fill set
  always_comb
  begin
    freeFound = 1'b0;
    freeWay   = '0;
    for (int i = 0; i < WAYS; i++)
    begin
      if (!entValid[{fillSet, WAY_W'(i)}] && !freeFound)
      begin
        freeFound = 1'b1;
        freeWay   = WAY_W'(i);
      end
    end
  end

  // Update overwrites the suspended entry, else invalid way, else victim
  assign wrEn  = fillValid;
  assign wrSet = fillUpdate ? modSet : fillSet;
  assign wrWay = fillUpdate ? modWay
               : (freeFound ? freeWay : missWay);
  // Walker result stored as given, nonresident included
  assign wrData = {fillPrivilege, fillAddr[31:16],
                   userAttrBitHi, userAttrBitLo, fillSupOnly,
                   cachePolicyField, fillModified, fillWriteProt,
                   fillResident, fillPhysPage};

  // ----------------------------------------------------------------
  // Valid and global flags, no reset so entries outlive it
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (anyFlushAll)
    begin
      for (int i = 0; i < SETS*WAYS; i++)
      begin
        if (!(anyFlushNg && entGlobal[i]))
        begin
          entValid[i] <= 1'b0;
        end
      end
    end
    else if (s1Flush)
    begin
      for (int i = 0; i < WAYS; i++)
      begin
        if (wayMatch[i] && !(s1FlushNg
            && entGlobal[{s1Set, WAY_W'(i)}]))
        begin
          entValid[{s1Set, WAY_W'(i)}] <= 1'b0;
        end
      end
    end
    if (wrEn)
    begin
      entValid[{wrSet, wrWay}]  <= 1'b1;
      entGlobal[{wrSet, wrWay}] <= fillGlobal;
    end
  end
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import xlc_pkg::*;
  typedef struct {logic [31:0] a; logic p; logic w; logic [27:0] d; logic [4:0] e;} xlc_row_s;
  xlc_row_s r;
  xlc_row_s rows [8] = '{'{32'h0000_1abc, 0, 0, 28'habc00a1, 5'h01},
    '{32'h0001_2120, 1, 1, 28'habc01aa, 5'h06}, '{32'h0003_3004, 0, 0, 28'habc02b3, 5'h0b},
    '{32'h0004_4008, 1, 0, 28'habc03b8, 5'h08}, '{32'h0005_5010, 0, 0, 28'habc04a7, 5'h10},
    '{32'h0006_6020, 1, 1, 28'habc05e1, 5'h10}, '{32'h0007_7030, 1, 0, 28'habc0621, 5'h10},
    '{32'h0008_8040, 1, 1, 28'habc0782, 5'h02}};
  logic mclk, rstn, psel, penable, pwrite, lookupValid, privilegeFlag, lookupWrite, glob, er;
  logic selectiveFlushOp, flushEveryEntryOp, flushNonGlobal, pready, pslverr, resultValid;
  logic resultHit, searchRequest, modifySuspend, busError, cacheInhibitOutput, copybackMode;
  logic serializeHold, userAttrOutLo, userAttrOutHi, fillValid, fillUpdate, fillPrivilege;
  logic fillGlobal, userAttrBitLo, userAttrBitHi, fillSupOnly, fillModified, fillWriteProt;
  logic fillResident;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, lookupAddr, resultPhysAddr, fillAddr, rd;
  logic [27:0] desc;
  logic [PA_W-1:0] fillPhysPage;
  logic [1:0] cachePolicyField;
  int errors, num_checks, cyc;
  xlc_translation_cache i_xlc_translation_cache (.mclk, .rstn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .lookupValid, .lookupAddr, .privilegeFlag, .lookupWrite,
    .lookupRmw(1'b0), .lookupAligned(1'b1), .resultValid, .resultPhysAddr, .resultHit,
    .searchRequest, .modifySuspend, .busError, .cacheInhibitOutput, .copybackMode, .serializeHold,
    .userAttrOutLo, .userAttrOutHi, .fillValid, .fillUpdate, .fillAddr, .fillPrivilege, .fillGlobal,
    .fillPhysPage, .userAttrBitLo, .userAttrBitHi, .fillSupOnly, .cachePolicyField, .fillModified,
    .fillWriteProt, .fillResident, .selectiveFlushOp, .flushEveryEntryOp, .flushNonGlobal,
    .flushAddr(lookupAddr), .flushPrivilege(privilegeFlag));
  xlc_walker i_xlc_walker (.mclk, .rstn, .searchRequest, .modifySuspend, .reqPriv(privilegeFlag),
    .glob, .reqAddr(lookupAddr), .desc, .fillValid, .fillUpdate, .fillPrivilege, .fillGlobal,
    .fillSupOnly, .userAttrBitLo, .userAttrBitHi, .fillModified, .fillWriteProt, .fillResident,
    .fillAddr, .fillPhysPage, .cachePolicyField);
  // Clock and hang guard
  initial
  begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      errors++;
      report_and_stop;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // APB transfer; read data and error taken where pready is high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // One lookup; returns just as its result pulse begins
  task automatic look(input logic [31:0] a, input logic p, input logic w);
    @(posedge mclk);
    lookupAddr <= a; privilegeFlag <= p; lookupWrite <= w; lookupValid <= 1;
    @(posedge mclk);
    lookupValid <= 0;
    @(posedge mclk) #1;
  endtask
  task automatic fill_wait;
    for (int k = 0; k < 20 && fillValid !== 1'b1; k++) @(posedge mclk) #1;
    chk("fill", 1, fillValid);
  endtask
  task automatic miss(input logic [31:0] a, input logic p, input logic w);
    look(a, p, w);
    chk("miss", 6, {resultValid, searchRequest, resultHit});
    fill_wait;
  endtask
  task automatic flush_all(input logic ng);
    @(posedge mclk);
    flushNonGlobal <= ng; flushEveryEntryOp <= 1;
    @(posedge mclk);
    flushEveryEntryOp <= 0;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    {rstn, psel, penable, pwrite, lookupValid, privilegeFlag, lookupWrite, glob} = '0;
    {selectiveFlushOp, flushEveryEntryOp, flushNonGlobal, paddr, pwdata, lookupAddr, desc} = '0;
    repeat (5) @(posedge mclk);
    rstn <= 1;
    look(32'h1234_5678, 0, 0);
    chk("bypass", 32'h1234_5678, resultPhysAddr);
    flush_all(0);
    apb(1, OFS_CTRL, 32'h2);
    apb(0, 12'h00c, 0);
    chk("unmapped", 1, er);
    $display("reset and bus done");
    foreach (rows[i])
    begin
      r = rows[i];
      desc <= r.d;
      glob <= (i == 3);
      miss(r.a, r.p, r.w);
      look(r.a, r.p, r.w);
      if (r.w && !r.d[5])
      begin
        chk("suspend", 3, {modifySuspend, searchRequest});
        fill_wait;
        look(r.a, r.p, r.w);
      end
      chk("hit", 1, resultHit);
      chk("flags", r.e, {busError, cacheInhibitOutput, copybackMode, userAttrOutHi,
        userAttrOutLo});
      chk("serial", r.d[4:3] == 2'h2, serializeHold);
      if (!r.e[4]) chk("phys", {r.d[27:8], r.a[11:0]}, resultPhysAddr);
      $display("case %0d done", i);
    end
    miss(32'h0001_1abc, 0, 0);
    apb(0, OFS_STAT, 0);
    chk("status", 1, rd[STAT_MISS_BIT]);
    miss(32'h0000_1abc, 1, 0);
    flush_all(1);
    miss(32'h0000_1abc, 0, 0);
    look(32'h0004_4008, 1, 0);
    chk("global kept", 1, resultHit);
    @(posedge mclk);
    flushNonGlobal <= 0; selectiveFlushOp <= 1;
    @(posedge mclk);
    selectiveFlushOp <= 0;
    miss(32'h0004_4008, 1, 0);
    $display("flush done");
    apb(1, OFS_CTRL, 32'h3);
    flush_all(0);
    desc <= 28'h13578a1;
    miss(32'h0001_3abc, 0, 0);
    look(32'h0001_3abc, 0, 0);
    chk("big pa12 set", 32'h1357_9abc, resultPhysAddr);
    look(32'h0001_2abc, 0, 0);
    chk("big pa12 clear", 32'h1357_8abc, resultHit ? resultPhysAddr : 0);
    $display("large page done");
    report_and_stop;
  end
endmodule
`default_nettype wire

// *** verif/xlc_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module xlc_checker
(
  // Clock, reset and lookup request
  input wire logic        mclk, rstn, lookupValid, selectiveFlushOp,
  input wire logic [31:0] lookupAddr,
  // Lookup result
  input wire logic        resultValid, resultHit, searchRequest, modifySuspend, busError,
  input wire logic        cacheInhibitOutput, copybackMode, serializeHold,
  input wire logic        userAttrOutLo, userAttrOutHi,
  input wire logic [31:0] resultPhysAddr
);
  logic        taken;  // Lookup accepted at this edge
  logic [11:0] ofs1;   // Page offset one stage on
  logic [11:0] ofs2;   // Page offset aligned with the result
  assign taken = lookupValid & ~selectiveFlushOp;
  // Offset pipeline matching the lookup latency
  always_ff @(posedge mclk)
  begin
    ofs1 <= lookupAddr[11:0];
    ofs2 <= ofs1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence answer_s; ##2 resultValid; endsequence
  lookup_latency_a: assert property (taken |-> answer_s)
    else $error("result late");
  result_cause_a: assert property (resultValid |-> $past(taken, 2))
    else $error("result without request");
  miss_search_a: assert property (resultValid && !resultHit |-> searchRequest)
    else $error("miss without search");
  offset_pass_a: assert property (resultValid && resultHit |-> resultPhysAddr[11:0] == ofs2)
    else $error("page offset altered");
  inhibit_hit_a: assert property (cacheInhibitOutput |-> resultHit && !copybackMode)
    else $error("inhibit without hit");
  copyback_hit_a: assert property (copybackMode |-> resultValid && resultHit)
    else $error("copyback without hit");
  serial_mode_a: assert property (serializeHold |-> cacheInhibitOutput)
    else $error("serialize outside inhibit");
  suspend_search_a: assert property (modifySuspend |-> searchRequest && resultHit)
    else $error("suspend without search");
  attr_mask_a: assert property (busError |-> !userAttrOutLo && !userAttrOutHi)
    else $error("attributes on fault");
endmodule
bind xlc_translation_cache xlc_checker i_xlc_checker (.mclk, .rstn, .lookupValid,
  .selectiveFlushOp, .lookupAddr, .resultValid, .resultHit, .searchRequest, .modifySuspend,
  .busError, .cacheInhibitOutput, .copybackMode, .serializeHold, .userAttrOutLo,
  .userAttrOutHi, .resultPhysAddr);
`default_nettype wire

// *** verif/xlc_walker.sv ***
`timescale 1ns/1ps
`default_nettype none
module xlc_walker
#(
  parameter int DLY = 3  // Search length in cycles, at least 2
)
(
  // Clock, reset and search requests
  input  wire logic        mclk, rstn, searchRequest, modifySuspend, reqPriv, glob,
  input  wire logic [31:0] reqAddr,
  input  wire logic [27:0] desc,
  // Entry fill
  output logic             fillValid, fillUpdate, fillPrivilege, fillGlobal, fillSupOnly,
  output logic             userAttrBitLo, userAttrBitHi, fillModified, fillWriteProt,
  output logic             fillResident,
  output logic [31:0]      fillAddr,
  output logic [19:0]      fillPhysPage,
  output logic [1:0]       cachePolicyField
);
  logic [DLY-1:0] pend;  // Searches in flight
  logic           upd;   // Search started by a modify suspension
  logic [61:0]    f;     // Entry built from the descriptor
  // Search timing and kind
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      pend <= '0;
      upd  <= 1'b0;
    end
    else
    begin
      pend <= {pend[DLY-2:0], searchRequest};
      if (searchRequest)
        upd <= modifySuspend;
    end
  end
  assign fillValid  = pend[DLY-1];
  assign fillUpdate = fillValid & upd;
  // Update search sets modified; resident and protect copied
  assign f = {reqAddr, reqPriv, glob, desc | {22'h0, upd, 5'h0}};
  // Idle fields show the inverse so a stale sample is caught
  assign {fillAddr, fillPrivilege, fillGlobal, fillPhysPage, fillResident, fillWriteProt,
          fillModified, cachePolicyField, fillSupOnly, userAttrBitHi, userAttrBitLo} =
         fillValid ? f : ~f;
endmodule
`default_nettype wire
